//--- rtl/readback_defines.svh
`ifndef READBACK_DEFINES_SVH
`define READBACK_DEFINES_SVH

// Stream layout
`define RB_DUMMY_BITS 8'h05
`define RB_ECHK_BITS 8'h04
`define RB_TAIL_ONES 8'h07
`define RB_FORCED_HEAD 8'h02
`define RB_CRC_BITS 8'h0B
`define RB_FRAMES 8'h04
`define RB_FRAME_DATA 8'h10
`define RB_ADDR_W 6
// Capture bits sit at the head of this frame
`define RB_CAP_FRAME 8'h01
`define RB_CAP_BITS 8'h07
// Generator polynomial, low 11 bits; value is arbitrary
`define RB_CRC_POLY 11'h205
`define RB_CRC_SEED 11'h000
// 5 + 4*(1+16+4) + 1 + 11
`define RB_TOTAL_BITS 8'h65
`define RB_FIFO_DEPTH 8
`define RB_SYNC_W 3

`endif

//--- rtl/readback_pkg.sv
package readback_pkg;
    typedef enum logic [2:0] {
        GEN_IDLE   = 3'b000,
        GEN_DUMMY  = 3'b001,
        GEN_START  = 3'b010,
        GEN_DATA   = 3'b011,
        GEN_ECHK   = 3'b100,
        GEN_FSTART = 3'b101,
        GEN_CRC    = 3'b110,
        GEN_DONE   = 3'b111
    } gen_state_t;
    typedef logic [7:0] count_t;
endpackage : readback_pkg

//--- rtl/stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(parameter int WIDTH = 1);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

//--- rtl/stream_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module stream_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input wire logic clock_in, // System clock
    input wire logic rst_in,   // Async reset, high
    input wire logic flush_in, // Drop all entries
    stream_if.snk wr,          // Filling side
    stream_if.src rd           // Draining side
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic full;
    logic empty;

    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign wr.ready = !full && !flush_in;
    assign rd.valid = !empty && !flush_in;
    assign rd.data = mem[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge clock_in) begin
        if (wr.valid && wr.ready) begin
            mem[wr_ptr_ff[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else if (flush_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (wr.valid && wr.ready) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (rd.valid && rd.ready) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
endmodule : stream_fifo
`default_nettype wire

//--- rtl/crc11_serial.sv
`timescale 1ns/1ns
`default_nettype none
`include "readback_defines.svh"
module crc11_serial (
    input wire logic clock_in,         // System clock
    input wire logic rst_in,           // Async reset, high
    input wire logic clear_in,         // Reload seed
    input wire logic enable_in,        // Absorb one bit
    input wire logic bit_in,           // Stream bit
    output logic [10:0] signature_out  // Running signature
);
    logic [10:0] sig_ff;
    logic feedback;

    assign feedback = sig_ff[10] ^ bit_in;
    assign signature_out = sig_ff;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sig_ff <= `RB_CRC_SEED;
        end else if (clear_in) begin
            sig_ff <= `RB_CRC_SEED;
        end else if (enable_in) begin
            sig_ff <= {sig_ff[9:0], 1'b0} ^ (feedback ? `RB_CRC_POLY : 11'h000);
        end
    end
endmodule : crc11_serial
`default_nettype wire

//--- rtl/config_readback_engine.sv
`timescale 1ns/1ns
`default_nettype none
`include "readback_defines.svh"
// What this block does
// RQ1: Trigger rise, then flag on next clock
// RQ2: One stream bit per later clock edge
// RQ3: No preamble; five ones, then start zero
// RQ4: First two data bits read as one
// RQ5: Bits returned uninverted
// RQ6: Four error-check ones close each frame
// RQ7: Last seven bits of last frame one
// RQ8: Start zero, 11-bit signature, then flag drops
// RQ9: Capture latches inverted node states at trigger
// RQ10: No capture: stored values at capture bits
// RQ11: RAM writes replace function-table bits
// RQ12: Abort on trigger fall, then rearm
// RQ13: Host may give extra clocks after abort
// RQ14: Everything on readback clock rising edges
// RQ15: Unconnected nets make readback impossible
// RQ16: Readback never disturbs user operation
// RQ17: Refused before configuration finish point
// RQ18: Frame: start zero, data, 4-bit field
// RQ19: Flag holds until signature ends or abort
module config_readback_engine
    import readback_pkg::*;
(
    input wire logic clock_in,                     // System clock, 125 MHz
    input wire logic rst_in,                       // Async reset, high
    input wire logic readback_trigger_in,          // Trigger net, async
    input wire logic readback_shift_clock_in,      // Readback clock net, async
    input wire logic configuration_clock_pin_in,   // Optional clock source, async
    input wire logic clock_select_cfg_in,          // Use the configuration clock
    input wire logic nets_connected_in,            // Control nets are routed
    input wire logic finish_point_reached_in,      // Configuration reached finish
    input wire logic capture_enable_in,            // State capture option
    input wire logic abort_enable_in,              // Abort option
    input wire logic [6:0] node_state_in,          // 4 block outs, iob ff, taps one/two
    input wire logic cfg_wr_en_in,                 // Configuration load strobe
    input wire logic [`RB_ADDR_W-1:0] cfg_wr_addr_in, // Load bit address
    input wire logic cfg_wr_data_in,               // Load bit value
    input wire logic ram_wr_en_in,                 // User RAM write strobe
    input wire logic [`RB_ADDR_W-1:0] ram_wr_addr_in, // RAM bit address
    input wire logic ram_wr_data_in,               // RAM bit value
    output logic readback_serial_out,              // Serial stream
    output logic read_in_progress_flag_out,        // Read in progress
    output logic readback_refused_out              // Last trigger refused
);
    localparam int NBITS = 64;

    logic [`RB_SYNC_W-1:0] async_bus;
    logic [`RB_SYNC_W-1:0] meta_ff;
    logic [`RB_SYNC_W-1:0] sync_ff;
    logic trig_prev_ff;
    logic clk_prev_ff;
    logic trig_rise;
    logic trig_fall;
    logic sel_clk;
    logic shift_edge;
    logic allowed;
    logic start_req;
    logic abort_req;

    logic mem_ff [NBITS];
    logic [6:0] capture_ff;
    logic armed_ff;
    logic rip_ff;
    logic serial_ff;
    logic refused_ff;
    count_t sent_ff;

    gen_state_t state_ff;
    gen_state_t nxt_state;
    count_t bit_cnt_ff;
    count_t nxt_bit_cnt;
    count_t frame_ff;
    count_t nxt_frame;
    logic cur_bit;
    logic data_bit;
    logic [`RB_ADDR_W-1:0] rd_addr;
    logic [10:0] signature;
    logic crc_en;
    logic push;

    stream_if #(.WIDTH(1)) fill_if ();
    stream_if #(.WIDTH(1)) drain_if ();

    assign async_bus = {configuration_clock_pin_in, readback_shift_clock_in, readback_trigger_in};

    // Two stages per asynchronous net
    genvar gi;
    generate
        for (gi = 0; gi < `RB_SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= async_bus[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    // RQ14: readback clock rising edges
    assign sel_clk = clock_select_cfg_in ? sync_ff[2] : sync_ff[1];

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            trig_prev_ff <= 1'b0;
            clk_prev_ff <= 1'b0;
        end else begin
            trig_prev_ff <= sync_ff[0];
            clk_prev_ff <= sel_clk;
        end
    end

    assign trig_rise = sync_ff[0] && !trig_prev_ff;
    assign trig_fall = !sync_ff[0] && trig_prev_ff;
    assign shift_edge = sel_clk && !clk_prev_ff;

    // RQ15: inhibit when unconnected
    // RQ17: refuse before finish point
    assign allowed = nets_connected_in && finish_point_reached_in;
    assign start_req = trig_rise && allowed && !armed_ff && !rip_ff;
    // RQ12: abort on falling trigger
    assign abort_req = trig_fall && abort_enable_in && (armed_ff || rip_ff);

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            refused_ff <= 1'b0;
        end else if (trig_rise) begin
            refused_ff <= !allowed;
        end
    end

    // RQ11: RAM writes overwrite table bits
    // RQ16: readback only reads this array
    always_ff @(posedge clock_in) begin
        if (ram_wr_en_in) begin
            mem_ff[ram_wr_addr_in] <= ram_wr_data_in;
        end else if (cfg_wr_en_in) begin
            mem_ff[cfg_wr_addr_in] <= cfg_wr_data_in;
        end
    end

    // RQ9: latch inverted node states
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            capture_ff <= 7'h00;
        end else if (start_req && capture_enable_in) begin
            capture_ff <= ~node_state_in;
        end
    end

    // RQ1: flag on first edge after trigger
    // RQ19: flag held until stream ends
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            armed_ff <= 1'b0;
            rip_ff <= 1'b0;
        end else if (abort_req) begin
            armed_ff <= 1'b0;
            rip_ff <= 1'b0;
        end else if (start_req) begin
            armed_ff <= 1'b1;
        end else if (shift_edge && armed_ff) begin
            armed_ff <= 1'b0;
            rip_ff <= 1'b1;
        end else if (shift_edge && rip_ff && sent_ff == `RB_TOTAL_BITS) begin
            // RQ8: drop after last signature bit
            rip_ff <= 1'b0;
        end
    end

    // RQ2: one bit per later edge
    assign drain_if.ready = shift_edge && rip_ff && (sent_ff != `RB_TOTAL_BITS);

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            serial_ff <= 1'b1;
            sent_ff <= 8'h00;
        end else if (abort_req || start_req) begin
            serial_ff <= 1'b1;
            sent_ff <= 8'h00;
        end else if (drain_if.ready && drain_if.valid) begin
            serial_ff <= drain_if.data[0];
            sent_ff <= sent_ff + 8'h01;
        end
    end

    assign rd_addr = `RB_ADDR_W'(frame_ff * `RB_FRAME_DATA + bit_cnt_ff);

    always_comb begin
        // RQ5: stored value passes uninverted
        data_bit = mem_ff[rd_addr];
        // RQ10: stored values unless capturing
        if (capture_enable_in && frame_ff == `RB_CAP_FRAME && bit_cnt_ff < `RB_CAP_BITS) begin
            data_bit = capture_ff[bit_cnt_ff[2:0]];
        end
        // RQ4: first two data bits one
        if (frame_ff == 8'h00 && bit_cnt_ff < `RB_FORCED_HEAD) begin
            data_bit = 1'b1;
        end
        // RQ7: tail of last frame one
        if (frame_ff == `RB_FRAMES - 8'h01 && bit_cnt_ff >= `RB_FRAME_DATA - `RB_TAIL_ONES) begin
            data_bit = 1'b1;
        end
    end

    always_comb begin
        case (state_ff)
            GEN_DUMMY: cur_bit = 1'b1;
            GEN_START: cur_bit = 1'b0;
            GEN_DATA: cur_bit = data_bit;
            GEN_ECHK: cur_bit = 1'b1;
            GEN_FSTART: cur_bit = 1'b0;
            GEN_CRC: cur_bit = signature[4'hA - bit_cnt_ff[3:0]];
            default: cur_bit = 1'b1;
        endcase
    end

    assign fill_if.valid = (state_ff != GEN_IDLE) && (state_ff != GEN_DONE);
    assign fill_if.data = cur_bit;
    assign push = fill_if.valid && fill_if.ready;
    assign crc_en = push
        && (state_ff == GEN_START || state_ff == GEN_DATA || state_ff == GEN_ECHK);

    always_comb begin
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_frame = frame_ff;
        if (push) begin
            nxt_bit_cnt = bit_cnt_ff + 8'h01;
            case (state_ff)
                // RQ3: five dummy ones first
                GEN_DUMMY: begin
                    if (bit_cnt_ff == `RB_DUMMY_BITS - 8'h01) begin
                        nxt_state = GEN_START;
                        nxt_bit_cnt = 8'h00;
                    end
                end
                // RQ18: start, data, check field
                GEN_START: begin
                    nxt_state = GEN_DATA;
                    nxt_bit_cnt = 8'h00;
                end
                GEN_DATA: begin
                    if (bit_cnt_ff == `RB_FRAME_DATA - 8'h01) begin
                        nxt_state = GEN_ECHK;
                        nxt_bit_cnt = 8'h00;
                    end
                end
                // RQ6: four check bits per frame
                GEN_ECHK: begin
                    if (bit_cnt_ff == `RB_ECHK_BITS - 8'h01) begin
                        nxt_bit_cnt = 8'h00;
                        nxt_frame = frame_ff + 8'h01;
                        nxt_state = (frame_ff == `RB_FRAMES - 8'h01) ? GEN_FSTART : GEN_START;
                    end
                end
                // RQ8: final start bit, then signature
                GEN_FSTART: begin
                    nxt_state = GEN_CRC;
                    nxt_bit_cnt = 8'h00;
                end
                GEN_CRC: begin
                    if (bit_cnt_ff == `RB_CRC_BITS - 8'h01) begin
                        nxt_state = GEN_DONE;
                        nxt_bit_cnt = 8'h00;
                    end
                end
                default: begin
                    nxt_bit_cnt = bit_cnt_ff;
                end
            endcase
        end
        if (state_ff == GEN_DONE && !rip_ff && !armed_ff) begin
            nxt_state = GEN_IDLE;
        end
    end

    // Generator fills ahead; FIFO back-pressure stalls it
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= GEN_IDLE;
            bit_cnt_ff <= 8'h00;
            frame_ff <= 8'h00;
        end else if (abort_req) begin
            state_ff <= GEN_IDLE;
            bit_cnt_ff <= 8'h00;
            frame_ff <= 8'h00;
        end else if (start_req) begin
            state_ff <= GEN_DUMMY;
            bit_cnt_ff <= 8'h00;
            frame_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            frame_ff <= nxt_frame;
        end
    end

    crc11_serial u_crc (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .clear_in(start_req),
        .enable_in(crc_en),
        .bit_in(cur_bit),
        .signature_out(signature)
    );

    // Abort flushes whatever was buffered ahead
    stream_fifo #(.WIDTH(1), .DEPTH(`RB_FIFO_DEPTH)) u_fifo (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .flush_in(abort_req || start_req),
        .wr(fill_if),
        .rd(drain_if)
    );

    assign readback_serial_out = serial_ff;
    assign read_in_progress_flag_out = rip_ff;
    assign readback_refused_out = refused_ff;
endmodule : config_readback_engine
`default_nettype wire

//--- bench/readback_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module readback_assertions (
    input wire logic clock_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic readback_trigger_in, // Trigger
    input wire logic readback_shift_clock_in, // Link clock
    input wire logic configuration_clock_pin_in, // Alt clock
    input wire logic clock_select_cfg_in, // Clock choice
    input wire logic nets_connected_in, // Nets routed
    input wire logic finish_point_reached_in, // Finish
    input wire logic abort_enable_in, // Abort option
    input wire logic readback_serial_out, // Stream
    input wire logic read_in_progress_flag_out, // Busy
    input wire logic readback_refused_out // Refused
);
    logic rclk, rise, prev_ff, flag_ff, in_frm, must1, must0;
    logic [3:0] since_ff;
    logic [7:0] cnt_ff, pos, frm;
    assign rclk = clock_select_cfg_in ? configuration_clock_pin_in : readback_shift_clock_in;
    assign rise = rclk && !prev_ff;
    assign pos = (cnt_ff - 8'h06) % 8'h15;
    assign frm = (cnt_ff - 8'h06) / 8'h15;
    assign in_frm = cnt_ff >= 8'h06 && cnt_ff <= 8'h59;
    assign must1 = (cnt_ff >= 8'h01 && cnt_ff <= 8'h05) || (in_frm && (pos >= 8'h11
        || (frm == 8'h00 && pos != 8'h00 && pos <= 8'h02) || (frm == 8'h03 && pos >= 8'h0A)));
    assign must0 = (in_frm && pos == 8'h00) || cnt_ff == 8'h5A;
    // Saturating age of the last raw clock rise keeps idle gaps quiet
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            prev_ff <= 1'b0;
            since_ff <= 4'hF;
        end else begin
            prev_ff <= rclk;
            if (rise) since_ff <= 4'h0;
            else if (since_ff != 4'hF) since_ff <= since_ff + 4'h1;
        end
    end
    // Edges seen since the flag rose; edge k leaves k-1 here
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            flag_ff <= 1'b0;
            cnt_ff <= 8'h00;
        end else begin
            flag_ff <= read_in_progress_flag_out;
            if (read_in_progress_flag_out && !flag_ff) cnt_ff <= 8'h00;
            else if (rise && read_in_progress_flag_out) cnt_ff <= cnt_ff + 8'h01;
        end
    end
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    a_flag_on_edge: assert property ($rose(read_in_progress_flag_out) |-> since_ff <= 4'h6)
        else $error("flag rose away from a clock edge");
    a_bit_per_edge: assert property (($changed(readback_serial_out)
        && read_in_progress_flag_out
        && $past(read_in_progress_flag_out)) |-> since_ff <= 4'h6) else $error("stray bit");
    a_fixed_ones: assert property ((read_in_progress_flag_out
        && since_ff == 4'h8 && must1) |-> readback_serial_out) else $error("fixed one missing");
    a_start_zeros: assert property ((read_in_progress_flag_out && since_ff == 4'h8
        && must0) |-> !readback_serial_out) else $error("start zero missing");
    a_flag_length: assert property ($fell(read_in_progress_flag_out)
        |-> cnt_ff == 8'h66 || abort_enable_in) else $error("flag length wrong");
    a_abort_drop: assert property ((abort_enable_in && $fell(readback_trigger_in)
        && read_in_progress_flag_out) |-> ##[1:6] !read_in_progress_flag_out)
        else $error("no abort");
    a_no_abort: assert property ((!abort_enable_in && $fell(readback_trigger_in)
        && read_in_progress_flag_out) |-> ##1 read_in_progress_flag_out[*5]) else $error("aborted");
    a_refuse_start: assert property (($rose(readback_trigger_in)
        && !read_in_progress_flag_out
        && !(nets_connected_in && finish_point_reached_in)) |-> ##[2:6] readback_refused_out)
        else $error("trigger not refused");
    a_refused_idle: assert property (readback_refused_out
        |-> !read_in_progress_flag_out) else $error("refused yet busy");
    c_start: cover property ($rose(read_in_progress_flag_out));
    c_full: cover property ($fell(read_in_progress_flag_out) && cnt_ff == 8'h66);
    c_abort: cover property (abort_enable_in && $fell(read_in_progress_flag_out));
endmodule : readback_assertions
`default_nettype wire

//--- bench/readback_collector.sv
`timescale 1ns/1ns
`default_nettype none
module readback_collector (
    input wire logic data_in, // Serial stream
    output logic clk_out // Readback clock
);
    logic got_q[$];
    initial begin
        clk_out = 1'b0;
    end
    // rising edges only
    // Called on a system clock edge; returns just before the tenth edge after it
    task automatic pulse_once();
        clk_out <= 1'b1;
        #40;
        clk_out <= 1'b0;
        // Sample late: the bit lands a few system cycles after the edge
        #39;
        got_q.push_back(data_in);
    endtask : pulse_once
endmodule : readback_collector
`default_nettype wire

//--- bench/config_readback_engine_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "readback_defines.svh"
`define CHK(g, e, m) begin checked++; \
    if ((g) !== (e)) begin error_cnt++; $display("BAD t=%0t %s", $time, m); end end
module config_readback_engine_tb;
    logic clock_in = 1'b0, rst_in = 1'b1, trig = 1'b0, sel = 1'b0, nets = 1'b1, fin = 1'b1;
    logic cap = 1'b0, abt = 1'b0, cwe = 1'b0, cwd = 1'b0, rwe = 1'b0, rwd = 1'b0;
    logic [6:0] node = 7'h00;
    logic [`RB_ADDR_W-1:0] cwa = '0, rwa = '0;
    logic so, flag, refused, pclk;
    logic mem[64];
    logic exp_b[101];
    int error_cnt = 0, checked = 0, cycles = 0;
    readback_collector col_u (.data_in(so), .clk_out(pclk));
    config_readback_engine dut_u (
        .clock_in(clock_in), .rst_in(rst_in), .readback_trigger_in(trig),
        .readback_shift_clock_in(sel ? 1'b0 : pclk),
        .configuration_clock_pin_in(sel ? pclk : 1'b0),
        .clock_select_cfg_in(sel), .nets_connected_in(nets), .finish_point_reached_in(fin),
        .capture_enable_in(cap), .abort_enable_in(abt), .node_state_in(node),
        .cfg_wr_en_in(cwe), .cfg_wr_addr_in(cwa), .cfg_wr_data_in(cwd),
        .ram_wr_en_in(rwe), .ram_wr_addr_in(rwa), .ram_wr_data_in(rwd),
        .readback_serial_out(so), .read_in_progress_flag_out(flag), .readback_refused_out(refused)
    );
    initial begin
        forever #4 clock_in = ~clock_in;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    // Whole run needs about 3700 cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("BAD t=%0t timeout", $time);
            summarize();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask : cyc
    task automatic wr(input logic [5:0] a, input logic d, input logic ram);
        @(posedge clock_in);
        rwe <= ram;
        rwa <= a;
        rwd <= d;
        cwe <= ~ram;
        cwa <= a;
        cwd <= d;
        mem[a] = d;
        @(posedge clock_in);
        cwe <= 1'b0;
        rwe <= 1'b0;
    endtask : wr
    function automatic void build(input logic capon, input logic [6:0] ns);
        logic [10:0] sig;
        logic fb;
        int i;
        sig = `RB_CRC_SEED;
        for (i = 0; i < 101; i++) exp_b[i] = 1'b1;
        for (int f = 0; f < 4; f++) begin
            exp_b[5+21*f] = 1'b0;
            for (int d = 0; d < 16; d++) begin
                exp_b[6+21*f+d] = mem[f*16+d];
                if (capon && f == 1 && d < 7) exp_b[6+21*f+d] = ~ns[d];
                if ((f == 0 && d < 2) || (f == 3 && d > 8)) exp_b[6+21*f+d] = 1'b1;
            end
        end
        exp_b[89] = 1'b0;
        for (i = 5; i < 89; i++) begin
            fb = sig[10] ^ exp_b[i];
            sig = {sig[9:0], 1'b0} ^ (fb ? `RB_CRC_POLY : 11'h000);
        end
        for (i = 0; i < 11; i++) exp_b[90+i] = sig[10-i];
    endfunction : build
    // The node inputs move after the trigger so a live copy would be caught
    task automatic rb(input int n, input int drop);
        @(posedge clock_in);
        build(cap, node);
        col_u.got_q.delete();
        trig <= 1'b1;
        cyc(6);
        for (int k = 1; k <= n; k++) begin
            col_u.pulse_once();
            @(posedge clock_in);
            if (k == 2) node <= ~node;
            if (k == drop) trig <= 1'b0;
            if (k == 1 && n > 3) `CHK(flag, 1'b1, "flag low after first edge")
            if (k == 102) `CHK(flag, 1'b1, "flag dropped early")
        end
        cyc(8);
    endtask : rb
    task automatic cmp_stream();
        `CHK(col_u.got_q.size(), 103, "sample count")
        for (int i = 0; i < 101; i++) `CHK(col_u.got_q[i+1], exp_b[i], "stream bit")
        `CHK(flag, 1'b0, "flag stuck high")
    endtask : cmp_stream
    initial begin
        cyc(6);
        rst_in <= 1'b0;
        cyc(2);
        `CHK({so, flag, refused}, 3'b100, "reset levels")
        for (int i = 0; i < 64; i++) wr(6'(i), i[0] ^ i[3] ^ i[5], 1'b0);
        wr(6'h01, 1'b0, 1'b0);
        wr(6'h14, 1'b1, 1'b1);
        rb(103, 40);
        cmp_stream();
        $display("test plain stream done");
        sel <= 1'b1;
        cap <= 1'b1;
        node <= 7'h35;
        // Trigger must come back low, or the refusal test sees no rising edge
        rb(103, 103);
        cmp_stream();
        $display("test capture done");
        for (int j = 0; j < 2; j++) begin
            nets <= j[0];
            fin <= ~j[0];
            rb(3, 3);
            `CHK({refused, flag}, 2'b10, "trigger taken")
        end
        $display("test refusal done");
        nets <= 1'b1;
        fin <= 1'b1;
        abt <= 1'b1;
        rb(30, 20);
        `CHK(flag, 1'b0, "abort ignored")
        repeat (4) begin
            col_u.pulse_once();
            @(posedge clock_in);
        end
        rb(103, 0);
        cmp_stream();
        `CHK(refused, 1'b0, "refusal stuck")
        $display("test abort done");
        summarize();
    end
endmodule : config_readback_engine_tb
bind config_readback_engine readback_assertions chk_u (.clock_in, .rst_in,
    .readback_trigger_in, .readback_shift_clock_in, .configuration_clock_pin_in,
    .clock_select_cfg_in, .nets_connected_in, .finish_point_reached_in, .abort_enable_in,
    .readback_serial_out, .read_in_progress_flag_out, .readback_refused_out);
`default_nettype wire
